// File: core/rnp_pkg.sv
// Constants for the reset, NMI and power-down pin logic
package rnp_pkg;
   // Clock rate and reset input filter time
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned RST_MIN_NS = 1000;
   localparam int unsigned RST_MIN_CYC =
      (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // Internal reset sequence length in cycles
   localparam int unsigned RST_SEQ_CYC = 1024;
   // Width of the cycle counters
   localparam int unsigned CNT_W = 16;
   // Reset values
   localparam logic RST_IND_RESET = 1'b0;
   localparam logic SLOW_OFF_RESET = 1'b0;
endpackage : rnp_pkg

// File: core/rnp_sync.sv
// Three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module rnp_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic async_i,
   output logic level_o
);
   logic [2:0] stage_q;

   // Only stage 2 reads stage 1; the level moves when stages 2 and 3 agree
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         stage_q <= {3{INIT}};
         level_o <= INIT;
      end else begin
         stage_q <= {stage_q[1:0], async_i};
         if (stage_q[1] == stage_q[2]) begin
            level_o <= stage_q[2];
         end
      end
   end
endmodule : rnp_sync

// File: core/rnp_top.sv
// Reset input, reset indication, NMI and power-down pin logic
// Operation
// - Reset pin held low for the minimum time starts an internal reset.
// - With bidir reset enabled as a pin, software or watchdog reset starts, pull reset pin low during its sequence.
// - Reset indication output low on hardware, software or watchdog reset.
// - Reset indication stays low until end-of-init instruction executes.
// - A falling NMI edge outside the reset sequence and power-down requests the NMI trap.
// - Config bit zero: power-down honoured only while NMI is low.
// - Config bit zero and NMI high: power-down ignored, keep running.
// - A control bit switches the slow oscillator off when unused.
`timescale 1ns/1ps
module rnp_top
   import rnp_pkg::*;
#(
   parameter int unsigned RST_MIN = RST_MIN_CYC,
   parameter int unsigned RST_SEQ = RST_SEQ_CYC
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic reset_in_pin_i,
   output logic reset_in_pin_o,
   output logic reset_in_pin_oe_o,
   input wire logic sw_reset_i,
   input wire logic wdt_reset_i,
   input wire logic end_of_init_instruction_i,
   input wire logic bidir_reset_enable_i,
   input wire logic powerdown_config_bit_i,
   input wire logic powerdown_instruction_i,
   input wire logic slow_osc_off_bit_i,
   input wire logic nmi_pin_i,
   output logic reset_indication_out_o,
   output logic int_reset_o,
   output logic nmi_trap_o,
   output logic powerdown_o,
   output logic slow_osc_off_o
);
   // Refuse counts that the counters cannot reach, at elaboration
   if (RST_MIN < 1 || RST_MIN >= (1 << CNT_W) ||
       RST_SEQ < 1 || RST_SEQ >= (1 << CNT_W)) begin : g_bad_count
      $error("rnp_top: counter parameters out of range");
   end

   localparam logic [CNT_W-1:0] MIN_L = CNT_W'(RST_MIN - 1);
   localparam logic [CNT_W-1:0] SEQ_L = CNT_W'(RST_SEQ - 1);

   typedef enum logic [1:0] {
      RNP_RUN = 2'b00,
      RNP_SEQ = 2'b01,
      RNP_INIT = 2'b10,
      RNP_PD = 2'b11
   } rnp_state_e;

   typedef struct packed {
      rnp_state_e st;
      logic [CNT_W-1:0] low_cnt;
      logic [CNT_W-1:0] seq_cnt;
      logic nmi_prev;
      logic pin_drive;
      logic pin_blank;
      logic ind;
      logic int_rst;
      logic trap;
      logic pd;
      logic osc_off;
   } rnp_state_s;

   rnp_state_s s_q, s_d;
   logic rst_pin_s;
   logic nmi_s;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   rnp_sync #(.INIT(1'b1)) u_rst_sync (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .async_i(reset_in_pin_i),
      .level_o(rst_pin_s)
   );

   rnp_sync #(.INIT(1'b1)) u_nmi_sync (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .async_i(nmi_pin_i),
      .level_o(nmi_s)
   );

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.trap = 1'b0;
      s_d.nmi_prev = nmi_s;
      s_d.osc_off = slow_osc_off_bit_i;
      // Blanking outlives our own drive until the synchronised pin reads
      // high again, so the synchroniser delay cannot retrigger; a source
      // that still holds the line low then counts only once it lets go
      if (s_q.pin_blank && !s_q.pin_drive && rst_pin_s) begin
         s_d.pin_blank = 1'b0;
      end
      // Low-time filter
      if (!rst_pin_s && !s_q.pin_blank) begin
         if (s_q.low_cnt != MIN_L) begin
            s_d.low_cnt = s_q.low_cnt + 1'b1;
         end
      end else begin
         s_d.low_cnt = '0;
      end
      case (s_q.st)
         RNP_RUN, RNP_INIT: begin
            // One trap per falling edge of the synchronised level
            if (s_q.nmi_prev && !nmi_s) begin
               s_d.trap = 1'b1;
            end
            if (s_q.st == RNP_INIT && end_of_init_instruction_i) begin
               s_d.st = RNP_RUN;
               s_d.ind = 1'b1;
            end
            if (s_q.st == RNP_RUN && powerdown_instruction_i &&
                (powerdown_config_bit_i || !nmi_s)) begin
               s_d.st = RNP_PD;
               s_d.pd = 1'b1;
            end
         end
         RNP_SEQ: begin
            if (s_q.seq_cnt == SEQ_L) begin
               s_d.st = RNP_INIT;
               s_d.int_rst = 1'b0;
               s_d.pin_drive = 1'b0;
            end else begin
               s_d.seq_cnt = s_q.seq_cnt + 1'b1;
            end
         end
         RNP_PD: begin
            // Only a reset leaves power-down here
            s_d.pd = 1'b1;
         end
         default: s_d.st = RNP_RUN;
      endcase
      // Any reset source restarts the sequence
      if ((!rst_pin_s && !s_q.pin_blank && s_q.low_cnt == MIN_L) ||
          sw_reset_i || wdt_reset_i) begin
         s_d.st = RNP_SEQ;
         s_d.seq_cnt = '0;
         s_d.int_rst = 1'b1;
         s_d.ind = 1'b0;
         s_d.pd = 1'b0;
         s_d.trap = 1'b0;
         s_d.pin_drive = bidir_reset_enable_i;
         s_d.pin_blank = bidir_reset_enable_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register; power-up reset runs the sequence
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         s_q <= '{st: RNP_SEQ, low_cnt: '0, seq_cnt: '0, nmi_prev: 1'b1,
                  pin_drive: 1'b0, pin_blank: 1'b0, ind: RST_IND_RESET,
                  int_rst: 1'b1, trap: 1'b0, pd: 1'b0,
                  osc_off: SLOW_OFF_RESET};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops, except the fixed pin value
   // The pin value is a fixed low: an open-drain pull, enabled only while
   // the sequence runs, so the external pull-up owns the high level
   assign reset_in_pin_o = 1'b0;
   assign reset_in_pin_oe_o = s_q.pin_drive;
   assign reset_indication_out_o = s_q.ind;
   assign int_reset_o = s_q.int_rst;
   assign nmi_trap_o = s_q.trap;
   assign powerdown_o = s_q.pd;
   assign slow_osc_off_o = s_q.osc_off;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_ind_low_reset: assert property (@(posedge clock_i) disable iff
      (!resetn_i) int_reset_o |-> !reset_indication_out_o)
      else $error("indication high during reset");
   a_ind_rise_init: assert property (@(posedge clock_i) disable iff
      (!resetn_i) $rose(reset_indication_out_o) |->
      $past(end_of_init_instruction_i))
      else $error("indication released without end of init");
   a_pin_drive_seq: assert property (@(posedge clock_i) disable iff
      (!resetn_i) reset_in_pin_oe_o |-> int_reset_o)
      else $error("pin driven outside reset sequence");
   a_bidir_drive: assert property (@(posedge clock_i) disable iff
      (!resetn_i) $rose(int_reset_o) && $past(bidir_reset_enable_i) &&
      !$past(int_reset_o) |-> reset_in_pin_oe_o)
      else $error("bidir reset not driving pin");
   a_no_self_retrig: assert property (@(posedge clock_i) disable iff
      (!resetn_i) s_q.pin_blank && !s_q.pin_drive && !sw_reset_i &&
      !wdt_reset_i |=> !int_reset_o)
      else $error("own pin drive restarted the reset");
   a_swrst_start: assert property (@(posedge clock_i) disable iff
      (!resetn_i) sw_reset_i || wdt_reset_i |=> int_reset_o &&
      !reset_indication_out_o)
      else $error("soft reset did not start sequence");
   a_trap_edge: assert property (@(posedge clock_i) disable iff
      (!resetn_i) nmi_trap_o |-> $past(s_q.nmi_prev) && !$past(nmi_s))
      else $error("trap without falling edge");
   a_trap_seq_off: assert property (@(posedge clock_i) disable iff
      (!resetn_i) int_reset_o |=> !nmi_trap_o)
      else $error("trap raised during reset sequence");
   a_trap_single: assert property (@(posedge clock_i) disable iff
      (!resetn_i) nmi_trap_o |=> !nmi_trap_o)
      else $error("trap longer than one cycle");
   a_pd_ignored: assert property (@(posedge clock_i) disable iff
      (!resetn_i) s_q.st == RNP_RUN && powerdown_instruction_i &&
      !powerdown_config_bit_i && nmi_s && !sw_reset_i && !wdt_reset_i &&
      s_q.low_cnt != MIN_L |=> !powerdown_o)
      else $error("power-down taken with NMI high");
   a_pd_taken: assert property (@(posedge clock_i) disable iff
      (!resetn_i) s_q.st == RNP_RUN && powerdown_instruction_i &&
      !powerdown_config_bit_i && !nmi_s && !sw_reset_i && !wdt_reset_i &&
      (rst_pin_s || s_q.low_cnt != MIN_L) |=> powerdown_o)
      else $error("power-down refused with NMI low");
   a_pd_hold: assert property (@(posedge clock_i) disable iff
      (!resetn_i) powerdown_o && !sw_reset_i && !wdt_reset_i &&
      (rst_pin_s || s_q.low_cnt != MIN_L) |=> powerdown_o)
      else $error("power-down left without a reset");
   a_osc_off: assert property (@(posedge clock_i) disable iff
      (!resetn_i) 1'b1 |=> slow_osc_off_o == $past(slow_osc_off_bit_i))
      else $error("slow oscillator control lost");
endmodule : rnp_top

// File: tb/rnp_ext_model.sv
// Model of the external reset source, pull-up and NMI driver
`timescale 1ns/1ps
module rnp_ext_model (
   input wire logic pull_i,
   input wire logic dev_oe_i,
   input wire logic dev_level_i,
   input wire logic nmi_level_i,
   output logic reset_line_o,
   output logic nmi_pin_o
);
   // Pull-up wins unless either party pulls the line low
   assign reset_line_o = !(pull_i || (dev_oe_i && !dev_level_i));
   // NMI source drives a plain level, idle high as if pulled up
   assign nmi_pin_o = nmi_level_i;
endmodule : rnp_ext_model

// File: tb/tb.sv
// Self-checking testbench for the reset, NMI and power-down pin logic
`timescale 1ns/1ps
module tb;
   import rnp_pkg::*;
   logic clock_i, resetn_i = 0, sw_reset_i = 0, wdt_reset_i = 0;
   logic end_of_init_instruction_i = 0, bidir_reset_enable_i = 0;
   logic powerdown_config_bit_i = 0, powerdown_instruction_i = 0;
   logic slow_osc_off_bit_i = 0, ext_pull = 0, nmi_lvl = 1;
   logic reset_in_pin_i, nmi_pin_i, reset_in_pin_o, reset_in_pin_oe_o;
   logic reset_indication_out_o, int_reset_o, nmi_trap_o, powerdown_o;
   logic slow_osc_off_o;
   int fail_count = 0, total_checks = 0, cyc = 0, traps = 0;
   // Rows: config bit, NMI level, expected power-down
   logic [2:0] rows [4] = '{3'b010, 3'b001, 3'b111, 3'b101};
   rnp_top #(.RST_MIN(4), .RST_SEQ(8)) rnp_top_i (.clock_i, .resetn_i,
      .reset_in_pin_i, .reset_in_pin_o, .reset_in_pin_oe_o, .sw_reset_i,
      .wdt_reset_i, .end_of_init_instruction_i, .bidir_reset_enable_i,
      .powerdown_config_bit_i, .powerdown_instruction_i,
      .slow_osc_off_bit_i, .nmi_pin_i, .reset_indication_out_o,
      .int_reset_o, .nmi_trap_o, .powerdown_o, .slow_osc_off_o);
   rnp_ext_model rnp_ext_model_i (.pull_i(ext_pull),
      .dev_oe_i(reset_in_pin_oe_o), .dev_level_i(reset_in_pin_o),
      .nmi_level_i(nmi_lvl), .reset_line_o(reset_in_pin_i),
      .nmi_pin_o(nmi_pin_i));
   ////////////////////////////////////////////////////////////////////////
   // Clock; a run far past the expected few hundred cycles is a hang
   initial begin
      clock_i = 0;
      forever #12.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         complete_run();
      end
   end
   // Trap pulses are counted mid-cycle, where the output has settled
   always @(negedge clock_i) begin
      if (nmi_trap_o === 1'b1) traps++;
   end
   ////////////////////////////////////////////////////////////////////////
   // Helpers; checks look at the falling edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask : tick
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_cnt(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_cnt
   // Bounded wait for the sequence end, then the end-of-init release
   task automatic finish_init();
      int n;
      n = 0;
      while (n < 60) begin
         @(negedge clock_i);
         if (int_reset_o === 1'b0) break;
         n++;
      end
      tick(3);
      @(negedge clock_i);
      chk_bit(int_reset_o, 1'b0);
      chk_bit(reset_indication_out_o, 1'b0);
      tick(1);
      end_of_init_instruction_i <= 1;
      tick(1);
      end_of_init_instruction_i <= 0;
      tick(1);
      @(negedge clock_i);
      chk_bit(reset_indication_out_o, 1'b1);
   endtask : finish_init
   task automatic complete_run();
      if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      tick(6);
      resetn_i <= 1;
      finish_init();
      foreach (rows[k]) begin
         tick(1);
         powerdown_config_bit_i <= rows[k][2];
         nmi_lvl <= rows[k][1];
         tick(8);
         powerdown_instruction_i <= 1;
         tick(1);
         powerdown_instruction_i <= 0;
         tick(1);
         @(negedge clock_i);
         chk_bit(powerdown_o, rows[k][0]);
         chk_bit(int_reset_o, 1'b0);
         tick(1);
         sw_reset_i <= 1;
         tick(1);
         sw_reset_i <= 0;
         nmi_lvl <= 1;
         tick(1);
         @(negedge clock_i);
         chk_bit(reset_indication_out_o, 1'b0);
         finish_init();
         chk_bit(powerdown_o, 1'b0);
      end
      // Watchdog reset with the device pulling the reset line
      tick(1);
      bidir_reset_enable_i <= 1;
      wdt_reset_i <= 1;
      tick(1);
      wdt_reset_i <= 0;
      tick(1);
      @(negedge clock_i);
      chk_bit(reset_indication_out_o, 1'b0);
      chk_bit(reset_in_pin_oe_o, 1'b1);
      chk_bit(reset_in_pin_i, 1'b0);
      chk_bit(reset_in_pin_o, 1'b0);
      finish_init();
      chk_bit(reset_in_pin_oe_o, 1'b0);
      // Short glitch is filtered, a long low level resets
      tick(1);
      bidir_reset_enable_i <= 0;
      ext_pull <= 1;
      tick(2);
      ext_pull <= 0;
      tick(10);
      @(negedge clock_i);
      chk_bit(int_reset_o, 1'b0);
      tick(1);
      ext_pull <= 1;
      tick(12);
      @(negedge clock_i);
      chk_bit(int_reset_o, 1'b1);
      tick(1);
      ext_pull <= 0;
      finish_init();
      // One falling NMI edge gives exactly one trap pulse
      tick(1);
      traps = 0;
      nmi_lvl <= 0;
      tick(10);
      nmi_lvl <= 1;
      tick(10);
      chk_cnt(traps, 1);
      // Slow oscillator switch follows its bit
      slow_osc_off_bit_i <= 1;
      tick(2);
      @(negedge clock_i);
      chk_bit(slow_osc_off_o, 1'b1);
      // Mid-run power-up reset: outputs return to their reset levels
      tick(1);
      resetn_i <= 0;
      tick(3);
      @(negedge clock_i);
      chk_bit(int_reset_o, 1'b1);
      chk_bit(reset_indication_out_o, RST_IND_RESET);
      chk_bit(reset_in_pin_oe_o, 1'b0);
      chk_bit(powerdown_o, 1'b0);
      chk_bit(slow_osc_off_o, SLOW_OFF_RESET);
      tick(1);
      resetn_i <= 1;
      finish_init();
      chk_bit(slow_osc_off_o, 1'b1);
      complete_run();
   end
endmodule : tb
